/* hw/lps_pkg.sv */
// Constants and types of the LED PWM serial control block.
// Assumes a sys_clk domain plus the host shift clock as link clock.
// Notes on behaviour
// - Over temperature sets flag, pulls error low
// - Flag held until first shift-clock fall after latch
// - Flag stays set if still over temperature
// - Flag is part of shifted status word
// - Four groups by output index modulo four
// - Groups switch on and off staggered
// - Outputs-off forces sinks off, counter reset
// - Outputs-off low: sinks follow PWM timing
// - Short enable: on-time is the shorter one
// - Serial output feeds next chained device
// - Mode low 192-bit level, high 96-bit trim
// - Half-select low enables extended interface
// - Latch pulses while off choose the half
// - Extended: output changes on falling edge
// - Extended: status only for upper half
// - Extended only in level mode
// - First rise after latch loads 17 status bits, level mode only
// - Shift in MSB first, latch on rise
// - Error low on flag or unmasked open LED
// - On-time equals level times count period; group zero is on from release, before the first count
package lps_pkg;
   localparam int CHANNELS    = 16;
   localparam int GROUPS      = 4;
   localparam int LEVEL_W     = 12;
   localparam int GS_LEN      = 192;
   localparam int TRIM_LEN    = 96;
   localparam int HALF_LEN    = 96;
   localparam int STATUS_W    = 17;
   localparam int GROUP_DELAY = 2;
   localparam int CNT_W       = 14;
   localparam int ASYNC_W     = 24;
   localparam int LINK_SYNC_W = 20;
   localparam logic RST_BIT   = 1'b0;
   typedef enum logic [1:0] {
      HALF_NONE,
      HALF_LOW,
      HALF_HIGH
   } lps_half_e;
endpackage

/* hw/lps_led_pwm.sv */
// PWM timing, serial shift path, status and error logic of a
// 16-sink LED driver. Expects the analog side to supply the open-LED
// and over-temperature levels and the host the serial pins.
`timescale 1ns/1ps
`default_nettype none
module lps_led_pwm
   import lps_pkg::*;
#(
   parameter int GRP_DELAY = GROUP_DELAY
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   input  wire logic                          shiftClk,
   input  wire logic                          serialDataIn,
   output logic                               serialDataOut,
   input  wire logic                          latchStrobe,
   input  wire logic                          outputsOff,
   input  wire logic                          trimModeSel,
   input  wire logic                          halfSelectN,
   input  wire logic                          pwmCountClock,
   input  wire logic                          overTempIn,
   input  wire logic [CHANNELS-1:0]           openLedFlag,
   output logic                               overTempFlag,
   output logic                               errorOutN,
   output logic                               errorOutNOe,
   output logic [CHANNELS-1:0]                sinkOutput,
   output logic [CHANNELS*LEVEL_W-1:0]        pwmLevel,
   output logic [TRIM_LEN-1:0]                currentTrim
);
   localparam int CNT_MAX = (1 << LEVEL_W) + (GROUPS - 1) * GRP_DELAY;

   // System domain state
   logic [ASYNC_W-1:0]          syncA_reg;
   logic [ASYNC_W-1:0]          syncB_reg;
   logic                        latchPrev_reg;
   logic                        pwmPrev_reg;
   logic                        clrPrev_reg;
   logic                        dataAck_reg;
   logic                        overTemp_reg;
   logic                        errOe_reg;
   logic [CNT_W-1:0]            cnt_reg;
   logic [CHANNELS-1:0]         sink_reg;
   logic [CHANNELS-1:0]         sink_next;
   logic [CHANNELS*LEVEL_W-1:0] level_reg;
   logic [TRIM_LEN-1:0]         trim_reg;
   lps_half_e                   half_reg;
   logic                        upperSel_reg;

   // Link domain state
   logic [GS_LEN-1:0]           shift_reg;
   logic [GS_LEN-1:0]           shift_next;
   logic [LINK_SYNC_W-1:0]      linkA_reg;
   logic [LINK_SYNC_W-1:0]      linkB_reg;
   logic                        armRise_reg;
   logic                        armFall_reg;
   logic                        clrTgl_reg;
   logic                        dataTgl_reg;
   logic                        soutFall_reg;

   // Decoded synchronised levels
   logic [CHANNELS-1:0]         openSync;
   logic                        otSync;
   logic                        pwmSync;
   logic                        halfNSync;
   logic                        trimSync;
   logic                        blankSync;
   logic                        latchSync;
   logic                        clrSync;
   logic                        dataSync;
   logic                        latchRise;
   logic                        pwmEdge;
   logic                        clrEvt;
   logic                        seenData;
   logic                        extGs;

   logic [CHANNELS-1:0]         linkOpen;
   logic                        linkOt;
   logic                        linkUpper;
   logic                        linkTrim;
   logic                        linkExt;
   logic [STATUS_W-1:0]         statusWord;

   // All pins except the shift clock and data, and the two link-domain toggles, pass two flops first
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         syncA_reg <= '0;
         syncB_reg <= '0;
      end else begin
         syncA_reg <= {openLedFlag, overTempIn, pwmCountClock,
                       halfSelectN, trimModeSel, outputsOff,
                       latchStrobe, clrTgl_reg, dataTgl_reg};
         syncB_reg <= syncA_reg;
      end
   end

   assign openSync  = syncB_reg[23:8];
   assign otSync    = syncB_reg[7];
   assign pwmSync   = syncB_reg[6];
   assign halfNSync = syncB_reg[5];
   assign trimSync  = syncB_reg[4];
   assign blankSync = syncB_reg[3];
   assign latchSync = syncB_reg[2];
   assign clrSync   = syncB_reg[1];
   assign dataSync  = syncB_reg[0];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         latchPrev_reg <= RST_BIT;
         pwmPrev_reg   <= RST_BIT;
         clrPrev_reg   <= RST_BIT;
      end else begin
         latchPrev_reg <= latchSync;
         pwmPrev_reg   <= pwmSync;
         clrPrev_reg   <= clrSync;
      end
   end

   assign latchRise = latchSync & ~latchPrev_reg;
   assign pwmEdge   = pwmSync & ~pwmPrev_reg;
   assign clrEvt    = clrSync ^ clrPrev_reg;
   assign seenData  = dataSync ^ dataAck_reg;
   assign extGs     = ~halfNSync & ~trimSync;

   // Over-temperature flag; a live condition beats the clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         overTemp_reg <= RST_BIT;
      end else if (otSync) begin
         overTemp_reg <= 1'b1;
      end else if (clrEvt) begin
         overTemp_reg <= 1'b0;
      end
   end

   // Open LEDs are masked while the outputs are off
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         errOe_reg <= RST_BIT;
      end else begin
         errOe_reg <= overTemp_reg | (|openSync & ~blankSync);
      end
   end

   // Half selection by latch pulses while outputs are off
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         half_reg    <= HALF_NONE;
         dataAck_reg <= RST_BIT;
      end else if (!extGs) begin
         half_reg    <= HALF_NONE;
         dataAck_reg <= dataSync;
      end else if (latchRise) begin
         if (seenData) begin
            half_reg    <= HALF_NONE;
            dataAck_reg <= dataSync;
         end else if (blankSync) begin
            unique case (half_reg)
               HALF_NONE: half_reg <= HALF_LOW;
               HALF_LOW:  half_reg <= HALF_HIGH;
               HALF_HIGH: half_reg <= HALF_HIGH;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         upperSel_reg <= RST_BIT;
      end else begin
         upperSel_reg <= extGs && (half_reg == HALF_HIGH);
      end
   end

   // Shift data is still while the latch is high, so a plain copy is safe
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         level_reg <= '0;
         trim_reg  <= '0;
      end else if (latchRise) begin
         if (trimSync) begin
            trim_reg <= shift_reg[TRIM_LEN-1:0];
         end else if (!extGs) begin
            level_reg <= shift_reg;
         end else if (seenData && half_reg == HALF_LOW) begin
            level_reg[HALF_LEN-1:0] <= shift_reg[HALF_LEN-1:0];
         end else if (seenData && half_reg == HALF_HIGH) begin
            level_reg[GS_LEN-1:HALF_LEN] <=
               shift_reg[HALF_LEN-1:0];
         end
      end
   end

   // Level counter, held at zero while the outputs are off
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
      end else if (blankSync) begin
         cnt_reg <= '0;
      end else if (pwmEdge && cnt_reg != CNT_W'(CNT_MAX)) begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   // Each group window is offset, so turn-off is staggered too
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_sink
         localparam logic [CNT_W-1:0] START =
            CNT_W'((ch % GROUPS) * GRP_DELAY);
         logic [CNT_W-1:0] lvl;
         assign lvl = CNT_W'(level_reg[ch*LEVEL_W +: LEVEL_W]);
         assign sink_next[ch] = !blankSync && cnt_reg >= START
                                && cnt_reg < START + lvl;
      end
   endgenerate

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sink_reg <= '0;
      end else begin
         sink_reg <= sink_next;
      end
   end

   // Link-domain copies of slow system levels
   always_ff @(posedge shiftClk or posedge rst) begin
      if (rst) begin
         linkA_reg <= '0;
         linkB_reg <= '0;
      end else begin
         linkA_reg <= {openSync, overTemp_reg, upperSel_reg,
                       trimModeSel, halfSelectN};
         linkB_reg <= linkA_reg;
      end
   end

   assign linkOpen   = linkB_reg[19:4];
   assign linkOt     = linkB_reg[3];
   assign linkUpper  = linkB_reg[2];
   assign linkTrim   = linkB_reg[1];
   assign linkExt    = ~linkB_reg[0] & ~linkB_reg[1];
   assign statusWord = {linkOpen, linkOt};

   // Armed by the latch itself; only the first edge afterwards sees it
   always_ff @(posedge shiftClk or posedge latchStrobe or posedge rst) begin
      if (rst) begin
         armRise_reg <= RST_BIT;
      end else if (latchStrobe) begin
         armRise_reg <= 1'b1;
      end else begin
         armRise_reg <= 1'b0;
      end
   end

   always_ff @(negedge shiftClk or posedge latchStrobe or posedge rst) begin
      if (rst) begin
         armFall_reg <= RST_BIT;
      end else if (latchStrobe) begin
         armFall_reg <= 1'b1;
      end else begin
         armFall_reg <= 1'b0;
      end
   end

   always_comb begin
      shift_next = {shift_reg[GS_LEN-2:0], serialDataIn};
      if (armRise_reg && !linkTrim) begin
         if (!linkExt) begin
            shift_next[GS_LEN-1 -: STATUS_W] = statusWord;
         end else if (linkUpper) begin
            shift_next[HALF_LEN-1 -: STATUS_W] = statusWord;
         end
      end
   end

   always_ff @(posedge shiftClk or posedge rst) begin
      if (rst) begin
         shift_reg   <= '0;
         dataTgl_reg <= RST_BIT;
      end else begin
         shift_reg <= shift_next;
         if (armRise_reg) begin
            dataTgl_reg <= ~dataTgl_reg;
         end
      end
   end

   // Falling-edge side: flag clear request and delayed output
   always_ff @(negedge shiftClk or posedge rst) begin
      if (rst) begin
         clrTgl_reg   <= RST_BIT;
         soutFall_reg <= RST_BIT;
      end else begin
         soutFall_reg <= shift_reg[HALF_LEN-1];
         if (armFall_reg) begin
            clrTgl_reg <= ~clrTgl_reg;
         end
      end
   end

   always_comb begin
      if (linkExt) begin
         serialDataOut = soutFall_reg;
      end else if (linkTrim) begin
         serialDataOut = shift_reg[TRIM_LEN-1];
      end else begin
         serialDataOut = shift_reg[GS_LEN-1];
      end
   end

   // Open-drain error pin only ever pulls low
   assign errorOutN    = 1'b0;
   assign errorOutNOe  = errOe_reg;
   assign overTempFlag = overTemp_reg;
   assign sinkOutput   = sink_reg;
   assign pwmLevel     = level_reg;
   assign currentTrim  = trim_reg;
endmodule
`default_nettype wire

/* bench/lps_led_pwm_properties.sv */
// Port checker of the LED PWM control block, sys_clk domain only.
// Bound to every lps_led_pwm; synchronizer lags set the repeat counts.
`timescale 1ns/1ps
`default_nettype none
module lps_led_pwm_properties
   import lps_pkg::*;
#(
   parameter int GRP_DELAY = GROUP_DELAY
) (
   input wire logic                        sys_clk,
   input wire logic                        rst,
   input wire logic                        outputsOff,
   input wire logic                        overTempIn,
   input wire logic [CHANNELS-1:0]         openLedFlag,
   input wire logic                        overTempFlag,
   input wire logic                        errorOutN,
   input wire logic                        errorOutNOe,
   input wire logic [CHANNELS-1:0]         sinkOutput,
   input wire logic [CHANNELS*LEVEL_W-1:0] pwmLevel
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_hot;
      overTempIn [*5];
   endsequence
   sequence s_calm;
      (openLedFlag == '0 && !overTempFlag) [*5];
   endsequence
   a_blank_all_off: assert property (outputsOff [*5] |-> sinkOutput == '0)
      else $error("sink on while blanked");
   a_hot_sets_flag: assert property (s_hot |-> overTempFlag)
      else $error("flag not set when hot");
   a_hot_keeps_flag: assert property (overTempIn [*6] |-> !$fell(overTempFlag))
      else $error("flag cleared while hot");
   a_flag_pulls_err: assert property (overTempFlag |=> errorOutNOe)
      else $error("error pin idle with flag set");
   a_err_quiet_idle: assert property (s_calm |-> !errorOutNOe)
      else $error("error pin low without cause");
   a_open_led_masked: assert property ((outputsOff && !overTempFlag) [*5] |-> !errorOutNOe)
      else $error("open LED not masked");
   a_zero_never_on: assert property ((pwmLevel[11:0] == 12'h000) [*2] |-> !sinkOutput[0])
      else $error("zero level sink on");
   a_group_stagger: assert property ($rose(sinkOutput[1]) && pwmLevel[11:0] > GRP_DELAY |-> sinkOutput[0])
      else $error("group one before group zero");
   a_err_pin_low: assert property (errorOutN == 1'b0)
      else $error("error pin value not low");
endmodule
bind lps_led_pwm lps_led_pwm_properties #(.GRP_DELAY(GRP_DELAY)) chk_u (.sys_clk, .rst,
   .outputsOff, .overTempIn, .openLedFlag, .overTempFlag, .errorOutN,
   .errorOutNOe, .sinkOutput, .pwmLevel);
`default_nettype wire

/* bench/lps_host_link.sv */
// Host model of the serial link: shift clock, data and latch strobe.
// Called by the bench top; shift clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module lps_host_link (
   output logic      shiftClk,
   output logic      serialDataIn,
   output logic      latchStrobe,
   input wire logic  serialDataOut
);
   logic [191:0] rdPre;
   logic [191:0] rdPost;
   initial begin
      shiftClk = 1'b0;
      serialDataIn = 1'b0;
      latchStrobe = 1'b0;
   end
   // MSB first at a 64 ns period, latch low throughout
   task automatic shift(input logic [191:0] d, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         serialDataIn = d[i];
         #16;
         rdPre = {rdPre[190:0], serialDataOut};
         shiftClk = 1'b1;
         #4;
         rdPost = {rdPost[190:0], serialDataOut};
         #28;
         shiftClk = 1'b0;
         #16;
      end
      // Released line must not look like a held bit
      serialDataIn = ~serialDataIn;
   endtask
   // Pulses also pick the half while blanked
   task automatic pulse();
      #20;
      latchStrobe = 1'b1;
      #40;
      latchStrobe = 1'b0;
      #40;
   endtask
endmodule
`default_nettype wire

/* bench/lps_led_pwm_tb_top.sv */
// Self-checking bench of the LED PWM control block.
// Assumes lps_host_link drives the link pins; sys_clk is 4 ns.
`timescale 1ns/1ps
`default_nettype none
module lps_led_pwm_tb_top;
   import lps_pkg::*;
   localparam int GD = 2;
   logic sys_clk = 1'b0;
   logic pwmCountClock = 1'b0;
   logic rst, outputsOff, trimModeSel, halfSelectN, overTempIn;
   logic overTempFlag, errorOutN, errorOutNOe;
   logic [CHANNELS-1:0] openLedFlag, sinkOutput;
   logic [CHANNELS*LEVEL_W-1:0] pwmLevel;
   logic [TRIM_LEN-1:0] currentTrim;
   wire logic shiftClk, serialDataIn, latchStrobe, serialDataOut;
   logic [191:0] d1, d2, t;
   int err_total = 0;
   int samples_checked = 0;
   int ph = 0;
   int lv [16];
   int fall [16];
   int onc [16];
   lps_led_pwm #(.GRP_DELAY(GD)) dut_u (.sys_clk, .rst, .shiftClk,
      .serialDataIn, .serialDataOut, .latchStrobe, .outputsOff, .trimModeSel,
      .halfSelectN, .pwmCountClock, .overTempIn, .openLedFlag, .overTempFlag,
      .errorOutN, .errorOutNOe, .sinkOutput, .pwmLevel, .currentTrim);
   lps_host_link host_u (.shiftClk, .serialDataIn, .latchStrobe, .serialDataOut);
   always #2 sys_clk = ~sys_clk;
   // Six-cycle count clock keeps both phases at three cycles
   always @(posedge sys_clk) begin
      ph <= (ph == 2) ? 0 : ph + 1;
      if (ph == 2) pwmCountClock <= ~pwmCountClock;
   end
   task automatic check(input logic [191:0] seen, input logic [191:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #300000;
      err_total++;
      $display("ERROR %0t watchdog expired", $time);
      complete_run();
   end
   initial begin
      rst = 1'b1;
      outputsOff = 1'b1;
      trimModeSel = 1'b0;
      halfSelectN = 1'b1;
      overTempIn = 1'b0;
      openLedFlag = '0;
      void'($urandom(1));
      for (int i = 0; i < 6; i++) d1[32*i+:32] = $urandom;
      for (int c = 0; c < 16; c++) begin
         lv[c] = (c == 0) ? 3 + $urandom % 37 : (c == 15 ? 0 : $urandom % 40);
         d2[12*c+:12] = 12'(lv[c]);
      end
      wt(8);
      rst <= 1'b0;
      wt(4);
      openLedFlag <= 16'($urandom);
      overTempIn <= 1'b1;
      host_u.shift(d1, 192);
      host_u.pulse();
      check(pwmLevel, d1);
      host_u.shift(d2, 192);
      check(host_u.rdPre[190:0], {openLedFlag, 1'b1, d1[173:0]});
      check(overTempFlag, 1'b1);
      overTempIn <= 1'b0;
      wt(20);
      check(overTempFlag, 1'b1);
      host_u.pulse();
      check(pwmLevel, d2);
      $display("status frames done");
      @(posedge sys_clk);
      outputsOff <= 1'b0;
      for (int k = 0; k < 400; k++) begin
         @(posedge sys_clk);
         for (int c = 0; c < 16; c++) begin
            onc[c] += sinkOutput[c];
            if (sinkOutput[c] === 1'b1) fall[c] = k;
         end
      end
      outputsOff <= 1'b1;
      wt(6);
      check(sinkOutput, 16'h0000);
      for (int c = 0; c < 16; c++) begin
         if (lv[c] == 0)
            check(onc[c], 0);
         else
            check(fall[c] - fall[0], ((c % 4) * GD + lv[c] - lv[0]) * 6);
         if (c % 4 != 0) check(onc[c], lv[c] * 6);
      end
      $display("pwm run done");
      // Trim frame with half-select low must act as plain trim
      halfSelectN <= 1'b0;
      trimModeSel <= 1'b1;
      t = {96'h0, 32'($urandom), 32'($urandom), 32'($urandom)};
      host_u.shift(t, 96);
      check(overTempFlag, 1'b0);
      host_u.pulse();
      check(currentTrim, t[95:0]);
      check(pwmLevel, d2);
      trimModeSel <= 1'b0;
      host_u.pulse();
      d1 = {96'h0, 32'($urandom), 32'($urandom), 32'($urandom)};
      // Two zero lead bits give the link side time to see the mode change
      host_u.shift(d1, 98);
      check(host_u.rdPre[97:2], t[95:0]);
      check(host_u.rdPost[95:0], host_u.rdPre[95:0]);
      host_u.pulse();
      check(pwmLevel, {d2[191:96], d1[95:0]});
      repeat (2) host_u.pulse();
      host_u.shift(t, 96);
      host_u.pulse();
      check(pwmLevel, {t[95:0], d1[95:0]});
      $display("trim and half frames done");
      complete_run();
   end
endmodule
`default_nettype wire
